// >>> atx_map.svh
// Register map, field positions, reset values and widths for the I2S transmit frame block
`ifndef ATX_MAP_SVH
`define ATX_MAP_SVH

// Printed offsets are not all multiples of four: they are indices
`define ATX_IDX_FRAME_DIV    16'h252c
`define ATX_IDX_MODE_CTRL    16'h252d
`define ATX_IDX_IFACE_CTRL   16'h2528
`define ATX_IDX_STATUS       16'h252f
`define ATX_ADDR_W           18

`define ATX_RST_FRAME_DIV    8'h00
`define ATX_RST_MODE_CTRL    8'h7e
`define ATX_RST_IFACE_CTRL   8'hc0

`define ATX_MODE_SHARE_BIT   7
`define ATX_MODE_MASTER_CLOCK_IDLE_POLARITY_BIT    6
`define ATX_MODE_REL_BIT     5
`define ATX_MODE_WIDTH_BIT   4
`define ATX_MODE_PULL_BIT    3
`define ATX_MODE_CHAN_HI     2
`define ATX_MODE_CHAN_LO     1
`define ATX_MODE_EN_BIT      0

`define ATX_IF_MS_BIT        7
`define ATX_IF_FMT_HI        6
`define ATX_IF_FMT_LO        5
`define ATX_IF_BCP_BIT       0

`define ATX_WORD_BITS        16
`define ATX_CNT_W            5

`endif

// >>> atx_pkg.sv
// Types shared by the I2S transmit frame block
package atx_pkg;

   typedef enum logic [1:0] {
      ATX_SILENT = 2'b00,
      ATX_RIGHT  = 2'b01,
      ATX_LEFT   = 2'b10,
      ATX_BOTH   = 2'b11
   } atx_chan_type;

   typedef enum logic [1:0] {
      ATX_FMT_I2S   = 2'b00,
      ATX_FMT_RIGHT = 2'b01,
      ATX_FMT_LEFT  = 2'b10,
      ATX_FMT_RSVD  = 2'b11
   } atx_fmt_type;

   typedef struct packed {
      logic mclk;
      logic bclk;
      logic lrck;
   } atx_clks_type;

   typedef struct packed {
      logic         share;
      logic         master_clock_idle_polarity;
      logic         rel;
      logic         width16;
      logic         pull;
      atx_chan_type chan;
      logic         enable;
   } atx_mode_type;

endpackage

// >>> atx_frame_div.sv
// Bit-clock to frame-clock divider with selectable edge
`timescale 1ns/1ps
`default_nettype none
module atx_frame_div
   import atx_pkg::*;
#(
   parameter int DIV_W = 8
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             run,
   input  wire logic [DIV_W-1:0] divider,
   input  wire logic             bclk_edge,
   output logic                  lrck,
   output logic                  lrck_toggle
);

   logic [DIV_W-1:0] count_q;

   // Half frame spans divider bit clocks: frame = bclk / (2 x divider)
   always_ff @(posedge aclk) begin
      if (!aresetn || !run || divider == '0) begin
         count_q <= '0;
         lrck    <= 1'b0;
      end else if (bclk_edge) begin
         if (count_q == divider - 1'b1) begin
            count_q <= '0;
            lrck    <= ~lrck;
         end else begin
            count_q <= count_q + 1'b1;
         end
      end
   end

   assign lrck_toggle = run && divider != '0 && bclk_edge
                        && count_q == divider - 1'b1;

endmodule // atx_frame_div
`default_nettype wire

// >>> atx_tx_ctrl.sv
// I2S transmit frame clock, mode control and serialiser with AXI4-Lite regs
//
// Contract
// - Frame clock is bit clock over twice divider
// - Divider zero stops the frame clock
// - Slave with share takes receiver clocks
// - Master clock idles high if polarity zero
// - Relation zero: frame changes on falling edge
// - Relation one: frame changes on rising edge
// - Width bit picks 16-bit or 8-bit moves
// - Pull bit allows automatic data transfer
// - Mode zero mutes, mode three sends both
// - Mode one right only, two left only
// - Enable bit turns the transmit port on
// - Format picks I2S or left justified; the right justified code acts as left
// - Inversion swaps the data change edge
// - Master drives clocks, slave takes them
`timescale 1ns/1ps
`default_nettype none
`include "atx_map.svh"
module atx_tx_ctrl
   import atx_pkg::*;
#(
   parameter int DIV_W = 8
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [`ATX_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [`ATX_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   own_mclk,
   input  wire logic                   own_bclk,
   input  wire logic                   rx_mclk,
   input  wire logic                   rx_bclk,
   input  wire logic                   rx_lrck,
   input  wire logic                   ext_mclk,
   input  wire logic                   ext_bclk,
   input  wire logic                   ext_lrck,
   input  wire logic [15:0]            pcm_data,
   input  wire logic                   pcm_valid,
   output logic                        pcm_ready,
   output logic                        pcm_half,
   output atx_clks_type                tx_clks,
   output logic                        tx_clks_oe,
   output logic                        tx_sdata
);

   ////////////////////////////////////////////////////////////////////////
   // Register file

   logic [7:0]   frame_div_q;
   logic [7:0]   mode_q;
   logic [7:0]   iface_q;
   atx_mode_type mode;
   atx_fmt_type  fmt;
   logic         master;
   logic         bit_clock_inversion;

   assign mode   = atx_mode_type'(mode_q);
   assign fmt    = atx_fmt_type'(iface_q[`ATX_IF_FMT_HI:`ATX_IF_FMT_LO]);
   assign master = iface_q[`ATX_IF_MS_BIT];
   assign bit_clock_inversion    = iface_q[`ATX_IF_BCP_BIT];

   function automatic logic [15:0] reg_index(
      input logic [`ATX_ADDR_W-1:0] a);
      reg_index = a[`ATX_ADDR_W-1:2];
   endfunction

   logic [`ATX_ADDR_W-1:0] awaddr_q;
   logic [31:0]            wdata_q;
   logic [3:0]             wstrb_q;
   logic                   aw_have_q;
   logic                   w_have_q;
   logic                   do_write;

   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
   assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         awaddr_q  <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_have_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (do_write) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q <= 1'b0;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_have_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (do_write) begin
         w_have_q <= 1'b0;
      end
   end

   logic wr_hit;
   assign wr_hit = reg_index(awaddr_q) == `ATX_IDX_FRAME_DIV
                || reg_index(awaddr_q) == `ATX_IDX_MODE_CTRL
                || reg_index(awaddr_q) == `ATX_IDX_IFACE_CTRL;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         frame_div_q <= `ATX_RST_FRAME_DIV;
         mode_q      <= `ATX_RST_MODE_CTRL;
         iface_q     <= `ATX_RST_IFACE_CTRL;
      end else if (do_write && wstrb_q[0]) begin
         unique case (reg_index(awaddr_q))
            `ATX_IDX_FRAME_DIV:  frame_div_q <= wdata_q[7:0];
            `ATX_IDX_MODE_CTRL:  mode_q      <= wdata_q[7:0];
            `ATX_IDX_IFACE_CTRL: iface_q     <= wdata_q[7:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   logic [7:0] status;
   logic       lrck;
   logic       chan_right_q;

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         unique case (reg_index(s_axi_araddr))
            `ATX_IDX_FRAME_DIV:  s_axi_rdata <= {24'h0, frame_div_q};
            `ATX_IDX_MODE_CTRL:  s_axi_rdata <= {24'h0, mode_q};
            `ATX_IDX_IFACE_CTRL: s_axi_rdata <= {24'h0, iface_q};
            `ATX_IDX_STATUS:     s_axi_rdata <= {24'h0, status};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock selection

   logic         run;
   logic         use_rx;
   atx_clks_type src;
   logic         bclk_q;
   logic         bclk_rise;
   logic         bclk_fall;
   logic         frame_edge;
   logic         data_edge;
   logic         gen_lrck;

   assign run    = mode.enable;
   assign use_rx = !master && mode.share;

   always_comb begin
      if (master) begin
         src = '{mclk: own_mclk, bclk: own_bclk, lrck: gen_lrck};
      end else if (use_rx) begin
         src = '{mclk: rx_mclk, bclk: rx_bclk, lrck: rx_lrck};
      end else begin
         src = '{mclk: ext_mclk, bclk: ext_bclk, lrck: ext_lrck};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bclk_q <= 1'b0;
      end else begin
         bclk_q <= src.bclk;
      end
   end

   assign bclk_rise  = src.bclk && !bclk_q;
   assign bclk_fall  = !src.bclk && bclk_q;
   assign frame_edge = mode.rel ? bclk_rise : bclk_fall;
   assign data_edge  = bit_clock_inversion ? bclk_rise : bclk_fall;

   atx_frame_div #(
      .DIV_W (DIV_W)
   ) u_div (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .run         (run && master),
      .divider     (frame_div_q),
      .bclk_edge   (frame_edge),
      .lrck        (gen_lrck),
      .lrck_toggle ()
   );

   assign lrck = src.lrck;

   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         tx_clks    <= '{mclk: 1'b1, bclk: 1'b0, lrck: 1'b0};
         tx_clks_oe <= 1'b0;
      end else begin
         tx_clks_oe <= master;
         tx_clks.bclk <= src.bclk;
         tx_clks.lrck <= src.lrck;
         tx_clks.mclk <= src.mclk;
      end
      if (aresetn && !run) begin
         tx_clks.mclk <= ~mode.master_clock_idle_polarity;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data pull and serialiser

   logic [15:0] left_q;
   logic [15:0] right_q;
   logic [15:0] shift_q;
   logic        byte_phase_q;
   logic        lrck_q;
   logic        word_start;
   logic        delay_q;
   logic [`ATX_CNT_W-1:0] bit_cnt_q;

   // Pull stalls while disabled or when pull is cleared
   assign pcm_ready = run && mode.pull;
   assign pcm_half  = !mode.width16;
   assign status    = {5'h0, chan_right_q, lrck, run};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         left_q       <= '0;
         right_q      <= '0;
         byte_phase_q <= 1'b0;
      end else if (pcm_valid && pcm_ready) begin
         if (mode.width16) begin
            left_q  <= right_q;
            right_q <= pcm_data;
         end else begin
            byte_phase_q <= ~byte_phase_q;
            if (byte_phase_q) begin
               right_q[7:0] <= pcm_data[7:0];
            end else begin
               left_q  <= right_q;
               right_q <= {pcm_data[7:0], 8'h00};
            end
         end
      end
   end

   function automatic logic [15:0] chan_word(
      input atx_chan_type m, input logic right, input logic [15:0] d);
      unique case (m)
         ATX_SILENT: chan_word = '0;
         ATX_RIGHT:  chan_word = right ? d : '0;
         ATX_LEFT:   chan_word = right ? '0 : d;
         ATX_BOTH:   chan_word = d;
      endcase
   endfunction

   // Left channel sits on the low frame level in I2S, high otherwise
   logic right_now;
   logic [15:0] next_word;
   assign right_now  = (fmt == ATX_FMT_I2S) ? lrck : !lrck;
   assign next_word  = chan_word(mode.chan, right_now,
                                 right_now ? right_q : left_q);
   assign word_start = data_edge && (lrck != lrck_q);

   always_ff @(posedge aclk) begin
      if (!aresetn || !run) begin
         lrck_q       <= 1'b0;
         shift_q      <= '0;
         tx_sdata     <= 1'b0;
         chan_right_q <= 1'b0;
         delay_q      <= 1'b0;
         bit_cnt_q    <= '0;
      end else if (data_edge) begin
         lrck_q <= lrck;
         if (word_start) begin
            chan_right_q <= right_now;
            shift_q <= next_word;
            delay_q <= fmt == ATX_FMT_I2S;
            bit_cnt_q <= '0;
            if (fmt != ATX_FMT_I2S) begin
               tx_sdata <= next_word[`ATX_WORD_BITS-1];
            end else begin
               // One-bit delay pushes the last bit past the frame edge
               tx_sdata <= !delay_q && shift_q[`ATX_WORD_BITS-2]
                           && bit_cnt_q < `ATX_CNT_W'(`ATX_WORD_BITS - 1);
            end
         end else if (delay_q) begin
            delay_q  <= 1'b0;
            tx_sdata <= shift_q[`ATX_WORD_BITS-1];
         end else if (bit_cnt_q < `ATX_CNT_W'(`ATX_WORD_BITS - 1)) begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
            shift_q   <= {shift_q[14:0], 1'b0};
            tx_sdata  <= shift_q[`ATX_WORD_BITS-2];
         end else begin
            tx_sdata <= 1'b0;
         end
      end
   end

endmodule // atx_tx_ctrl
`default_nettype wire

// >>> atx_tx_ctrl_sva.sv
// Assertion checker for the transmit frame and mode block
`timescale 1ns/1ps
`default_nettype none
`include "atx_map.svh"
module atx_tx_ctrl_chk
   import atx_pkg::*;
(
   input wire logic         aclk,
   input wire logic         aresetn,
   input wire logic [17:0]  s_axi_awaddr,
   input wire logic         s_axi_awvalid,
   input wire logic         s_axi_awready,
   input wire logic [31:0]  s_axi_wdata,
   input wire logic [3:0]   s_axi_wstrb,
   input wire logic         s_axi_wvalid,
   input wire logic         s_axi_wready,
   input wire logic [1:0]   s_axi_bresp,
   input wire logic         s_axi_bvalid,
   input wire logic         s_axi_bready,
   input wire logic         rx_bclk,
   input wire logic         pcm_ready,
   input wire logic         pcm_half,
   input wire atx_clks_type tx_clks,
   input wire logic         tx_clks_oe,
   input wire logic         tx_sdata
);
   logic [7:0] div_q;
   logic [7:0] mode_q;
   logic [7:0] if_q;
   logic       wr;
   assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid
               && s_axi_wready && s_axi_wstrb[0];
   // Shadow copies of the registers as written over the bus
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_q  <= `ATX_RST_FRAME_DIV;
         mode_q <= `ATX_RST_MODE_CTRL;
         if_q   <= `ATX_RST_IFACE_CTRL;
      end else if (wr) begin
         if (s_axi_awaddr == `ATX_IDX_FRAME_DIV * 4)
            div_q <= s_axi_wdata[7:0];
         if (s_axi_awaddr == `ATX_IDX_MODE_CTRL * 4)
            mode_q <= s_axi_wdata[7:0];
         if (s_axi_awaddr == `ATX_IDX_IFACE_CTRL * 4)
            if_q <= s_axi_wdata[7:0];
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////
   property p_div_zero;
      (div_q == 8'h00 && if_q[7])[*4] |-> !tx_clks.lrck;
   endproperty
   a_div_zero: assert property (p_div_zero)
      else $error("frame clock active with zero divider");
   property p_idle;
      (!mode_q[0])[*4] |-> !tx_clks.lrck && !tx_sdata && !tx_clks_oe;
   endproperty
   a_idle: assert property (p_idle)
      else $error("disabled port not idle");
   property p_mclk_idle;
      ($stable(mode_q) && !mode_q[0])[*4] |-> tx_clks.mclk == !mode_q[6];
   endproperty
   a_mclk_idle: assert property (p_mclk_idle)
      else $error("master clock idle level wrong");
   property p_pull;
      $stable(mode_q)[*2] |-> pcm_ready == (mode_q[0] && mode_q[3]);
   endproperty
   a_pull: assert property (p_pull)
      else $error("data pull does not follow mode");
   property p_width;
      $stable(mode_q)[*2] |-> pcm_half == !mode_q[4];
   endproperty
   a_width: assert property (p_width)
      else $error("transfer width does not follow mode");
   property p_oe;
      $stable({mode_q, if_q})[*3] |-> tx_clks_oe == (mode_q[0] && if_q[7]);
   endproperty
   a_oe: assert property (p_oe)
      else $error("clock drive does not follow master and enable");
   property p_share;
      (mode_q[0] && mode_q[7] && !if_q[7] && $stable(rx_bclk))[*4]
         |-> tx_clks.bclk == rx_bclk;
   endproperty
   a_share: assert property (p_share)
      else $error("shared bit clock not taken from receiver");
   property p_bstand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bstand: assert property (p_bstand)
      else $error("write response dropped before accepted");
   c_frame: cover property ($rose(tx_clks.lrck));
   c_share: cover property (mode_q[7] && mode_q[0] && !if_q[7]);
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
endmodule // atx_tx_ctrl_chk

bind atx_tx_ctrl atx_tx_ctrl_chk u_chk (
   .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .rx_bclk, .pcm_ready,
   .pcm_half, .tx_clks, .tx_clks_oe, .tx_sdata
);
`default_nettype wire

// >>> atx_conv_model.sv
// Model of the external audio converter on the serial link
`timescale 1ns/1ps
`default_nettype none
module atx_conv_model
   import atx_pkg::*;
#(
   parameter int HALF = 2
) (
   input  wire logic         aclk,
   input  wire logic         run,
   input  wire atx_clks_type clks,
   input  wire logic         sdata,
   output logic              mclk,
   output logic              bclk,
   output logic              lrck,
   output int                hi_l,
   output int                hi_r
);
   int         cnt_q = 0;
   logic [3:0] bit_q = 4'h0;
   logic       prev_q = 1'b0;
   initial {mclk, bclk, lrck, hi_l, hi_r} = '0;
   // Clocks stand still while run is low
   always @(posedge aclk) begin
      if (!run) begin
         cnt_q <= 0;
         mclk <= 1'b0;
         bclk <= 1'b0;
      end else begin
         mclk <= !mclk;
         cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
         if (cnt_q == HALF - 1) begin
            bclk <= !bclk;
            if (bclk) begin
               bit_q <= bit_q + 4'h1;
               if (bit_q == 4'hf)
                  lrck <= !lrck;
            end
         end
      end
   end
   // Counts ones received per channel, left while frame clock is high
   always @(posedge aclk) begin
      prev_q <= clks.bclk;
      if (clks.bclk && !prev_q && sdata) begin
         if (clks.lrck)
            hi_l <= hi_l + 1;
         else
            hi_r <= hi_r + 1;
      end
   end
endmodule // atx_conv_model
`default_nettype wire

// >>> atx_tx_ctrl_bench.sv
// Self-checking testbench for the transmit frame and mode block
`timescale 1ns/1ps
`default_nettype none
`include "atx_map.svh"
module atx_tx_ctrl_bench
   import atx_pkg::*;
;
   localparam int HALF = 2;
   localparam int LIMIT = 20000;
   localparam logic [17:0] A_DIV = 18'(`ATX_IDX_FRAME_DIV * 4);
   localparam logic [17:0] A_MODE = 18'(`ATX_IDX_MODE_CTRL * 4);
   localparam logic [17:0] A_IF = 18'(`ATX_IDX_IFACE_CTRL * 4);
   localparam logic [17:0] A_BAD = 18'h00100;
   logic         aclk = 1'b0;
   logic         aresetn = 1'b0;
   logic [17:0]  s_axi_awaddr = '0;
   logic [17:0]  s_axi_araddr = '0;
   logic [31:0]  s_axi_wdata = '0;
   logic [31:0]  s_axi_rdata;
   logic [3:0]   s_axi_wstrb = 4'hf;
   logic [1:0]   s_axi_bresp;
   logic [1:0]   s_axi_rresp;
   logic         s_axi_awvalid = 1'b0;
   logic         s_axi_wvalid = 1'b0;
   logic         s_axi_bready = 1'b0;
   logic         s_axi_arvalid = 1'b0;
   logic         s_axi_rready = 1'b0;
   logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic         s_axi_arready, s_axi_rvalid;
   logic [15:0]  pcm_data = 16'hffff;
   logic         pcm_valid = 1'b0;
   logic         pcm_ready, pcm_half, tx_clks_oe, tx_sdata;
   atx_clks_type tx_clks;
   logic         run = 1'b0;
   logic         rx_run = 1'b0;
   logic [7:0]   rx_cnt = 8'h00;
   logic         c_mclk, c_bclk, c_lrck, bclk_p, lrck_p, sclk_p;
   int           hi_l, hi_r, since_rise, since_lrck, period, offset;
   int           nlrck = 0;
   int           nbclk = 0;
   int           cycles = 0;
   int           mismatches = 0;
   int           checked = 0;
   always #2.5 aclk = !aclk;
   atx_tx_ctrl u_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .own_mclk(c_mclk), .own_bclk(c_bclk),
      .rx_mclk(rx_cnt[0]), .rx_bclk(rx_cnt[3]), .rx_lrck(rx_cnt[7]),
      .ext_mclk(c_mclk), .ext_bclk(c_bclk), .ext_lrck(c_lrck), .pcm_data,
      .pcm_valid, .pcm_ready, .pcm_half, .tx_clks, .tx_clks_oe, .tx_sdata
   );
   atx_conv_model #(.HALF(HALF)) u_conv (
      .aclk, .run, .clks(tx_clks), .sdata(tx_sdata), .mclk(c_mclk),
      .bclk(c_bclk), .lrck(c_lrck), .hi_l, .hi_r
   );
   ////////////////////////////////////////////////////////////////////////
   // Frame clock timing monitor and hang guard
   always @(posedge aclk) begin
      if (rx_run)
         rx_cnt <= rx_cnt + 8'h01;
      bclk_p <= c_bclk;
      lrck_p <= tx_clks.lrck;
      sclk_p <= tx_clks.bclk;
      since_rise <= (c_bclk && !bclk_p) ? 1 : since_rise + 1;
      since_lrck <= since_lrck + 1;
      if (tx_clks.bclk !== sclk_p)
         nbclk <= nbclk + 1;
      if (tx_clks.lrck !== lrck_p) begin
         nlrck <= nlrck + 1;
         period <= since_lrck;
         offset <= since_rise;
         since_lrck <= 1;
      end
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         mismatches++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (mismatches == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [17:0] a, input logic [7:0] d,
                     input logic [1:0] e);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!(ad && wd));
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
      cmp(s_axi_bresp, e);
   endtask
   task automatic rd(input logic [17:0] a, input logic [31:0] d,
                     input logic [1:0] e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_rready <= 1'b0;
      cmp(s_axi_rdata, d);
      cmp(s_axi_rresp, e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rd(A_DIV, 32'h00, 2'b00);
      rd(A_MODE, 32'h7e, 2'b00);
      rd(A_IF, 32'hc0, 2'b00);
      rd(A_BAD, 32'h00, 2'b10);
      wr(A_BAD, 8'h55, 2'b10);
   endtask
   task automatic t_idle();
      int n0;
      run <= 1'b1;
      wr(A_DIV, 8'h01, 2'b00);
      wr(A_MODE, 8'h3e, 2'b00);
      idle(20);
      n0 = nlrck;
      idle(40);
      cmp(nlrck - n0, 0);
      cmp({tx_clks.mclk, tx_clks.lrck, tx_sdata, tx_clks_oe}, 4'h8);
      wr(A_MODE, 8'h7e, 2'b00);
      idle(20);
      cmp({tx_clks.mclk, tx_clks.lrck, tx_sdata, tx_clks_oe}, 4'h0);
   endtask
   task automatic t_period();
      int d;
      int o1;
      int n0;
      for (d = 1; d <= 3; d += 2) begin
         wr(A_DIV, d[7:0], 2'b00);
         wr(A_MODE, 8'h7f, 2'b00);
         idle(8 * d * HALF + 40);
         cmp(period, d * 2 * HALF);
      end
      o1 = offset;
      wr(A_MODE, 8'h5e, 2'b00);
      wr(A_IF, 8'hc1, 2'b00);
      wr(A_MODE, 8'h5f, 2'b00);
      idle(60);
      cmp((offset + 2 * HALF - o1) % (2 * HALF), HALF);
      wr(A_MODE, 8'h7e, 2'b00);
      wr(A_IF, 8'hc0, 2'b00);
      wr(A_MODE, 8'h7f, 2'b00);
      wr(A_DIV, 8'h00, 2'b00);
      idle(20);
      n0 = nlrck;
      idle(60);
      cmp(nlrck - n0, 0);
      cmp(tx_clks.lrck, 0);
   endtask
   task automatic t_width();
      wr(A_MODE, 8'h6f, 2'b00);
      idle(2);
      cmp({pcm_half, pcm_ready, tx_clks_oe}, 3'h7);
      wr(A_MODE, 8'h77, 2'b00);
      idle(2);
      cmp({pcm_half, pcm_ready}, 2'h0);
   endtask
   task automatic t_chan();
      int m;
      int l0;
      int r0;
      wr(A_DIV, 8'h10, 2'b00);
      pcm_valid <= 1'b1;
      for (m = 0; m < 4; m++) begin
         wr(A_MODE, 8'h79 | 8'(m << 1), 2'b00);
         idle(300);
         l0 = hi_l;
         r0 = hi_r;
         idle(512);
         cmp({hi_l - l0 > 24, hi_r - r0 > 24}, m);
      end
      pcm_valid <= 1'b0;
   endtask
   task automatic t_i2s();
      int l0;
      int r0;
      pcm_valid <= 1'b1;
      wr(A_IF, 8'h81, 2'b00);
      wr(A_MODE, 8'h7d, 2'b00);
      idle(300);
      l0 = hi_l;
      r0 = hi_r;
      idle(512);
      cmp({hi_l - l0 > 24, hi_r - r0 > 24}, 2'h1);
      pcm_valid <= 1'b0;
      wr(A_IF, 8'hc0, 2'b00);
   endtask
   task automatic t_share();
      int n0;
      run <= 1'b0;
      rx_run <= 1'b1;
      wr(A_IF, 8'h40, 2'b00);
      wr(A_MODE, 8'hff, 2'b00);
      idle(20);
      n0 = nbclk;
      idle(200);
      cmp({nbclk - n0 > 10, tx_clks_oe}, 2'h2);
      wr(A_MODE, 8'h7f, 2'b00);
      idle(20);
      n0 = nbclk;
      idle(200);
      cmp(nbclk - n0, 0);
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_idle();
      t_period();
      t_width();
      t_chan();
      t_i2s();
      t_share();
      give_verdict();
   end
endmodule // atx_tx_ctrl_bench
`default_nettype wire
